/* File: core/fault_manager.sv */
// Fault and warning supervisor of a field-bus motor starter.
// Assumes synchronous master-side inputs and asynchronous detector pins.
// Function
// [RULE1] Bus loss: bus fault bit, red bus lamp, substitute/held outputs.
// [RULE2] Master stop: stop bit, bus lamp off, substitute/held outputs.
// [RULE3] Electronics undervoltage trips, red group lamp, clears itself.
// [RULE4] Switching supply undervoltage trips, red group lamp, clears itself.
// [RULE5] No mains with motor off: only no-mains bit, no trip.
// [RULE6] No mains with motor on: trip, needs explicit trip reset.
// [RULE7] Sensor supply overload trips, cleared only by trip reset.
// [RULE8] Sensor overload in warning mode: warning, flashing lamp, auto.
// [RULE9] Sensor overload in trip mode: trip, reset refused while hot.
// [RULE10] Sensor short in warning mode: warning, flashing lamp, auto.
// [RULE11] Sensor short in trip mode: trip, reset after short is gone.
// [RULE12] Sensor wire break: warning or trip like the other sensor faults.
// [RULE13] Model overload trip: reset only after cooling, time reported.
// [RULE14] Self-test failure trips, red lamps, cleared by power cycle.
// [RULE15] Defective element trips, three red lamps, power cycle only.
// [RULE16] Auto-acknowledged faults clear with their cause, unlike autoreset.
// [RULE17] Image error trips; withdrawing both direction commands clears it.
// [RULE18] Latched trips keep motor off and ignore on commands.
`timescale 1ns/1ps
module fault_manager #(
   parameter int COOL_W = 16
) (
   // Clock and reset
   input  wire logic                    clk_sys,
   input  wire logic                    reset_n,
   // Register port
   input  wire logic [7:0]              addr,
   input  wire logic [31:0]             wdata,
   input  wire logic                    wr,
   input  wire logic                    rd,
   output      logic [31:0]             rdata,
   // Master side, same clock
   input  wire logic                    bus_ok,
   input  wire logic                    master_run,
   input  wire logic                    cmd_cw,
   input  wire logic                    cmd_ccw,
   input  wire logic                    trip_reset,
   input  wire logic [COOL_W-1:0]       cool_time,
   // Detector pins
   input  wire fault_mgr_pkg::cond_t    cond_in,
   // Motor outputs, signalling, lamps, interrupt
   output      logic                    motor_cw,
   output      logic                    motor_ccw,
   output      fault_mgr_pkg::sig_t     signals,
   output      fault_mgr_pkg::lamps_t   lamps,
   output      logic                    irq
);
   typedef struct packed {
      fault_mgr_pkg::cond_t                  sync1;
      fault_mgr_pkg::cond_t                  sync2;
      logic [fault_mgr_pkg::CFG_W-1:0]       cfg;
      fault_mgr_pkg::latch_t                 lat;
      logic                                  mcw;
      logic                                  mccw;
      fault_mgr_pkg::sig_t                   sig;
      fault_mgr_pkg::lamps_t                 lmp;
      logic [fault_mgr_pkg::IRQ_W-1:0]       istat;
      logic [fault_mgr_pkg::IRQ_W-1:0]       imask;
      logic [COOL_W-1:0]                     cool;
      logic [31:0]                           rdat;
   } state_t;

   state_t s;
   state_t next_s;

   // Latch update: set wins, clears on ack once the cause is gone
   function automatic logic hold_latch(input logic cur, input logic set,
                                       input logic cause, input logic ack);
      hold_latch = set | (cur & ~(ack & ~cause));
   endfunction

   // Register read value
   function automatic logic [31:0] read_mux(input logic [7:0] a,
                                            input state_t st);
      read_mux = 32'h0;
      case (a)
         fault_mgr_pkg::REG_CFG:      read_mux = 32'(st.cfg);
         fault_mgr_pkg::REG_SIGNAL:   read_mux = 32'(st.sig);
         fault_mgr_pkg::REG_IRQ_STAT: read_mux = 32'(st.istat);
         fault_mgr_pkg::REG_IRQ_MASK: read_mux = 32'(st.imask);
         fault_mgr_pkg::REG_COOL:     read_mux = 32'(st.cool);
         default:                     read_mux = 32'h0;
      endcase
   endfunction

   logic                            motor_on;
   logic                            sens_trip;
   logic                            model_trip;
   logic                            ack;
   logic                            trip;
   fault_mgr_pkg::cond_t            c;
   logic [fault_mgr_pkg::IRQ_W-1:0] ev;

   assign motor_on   = cmd_cw | cmd_ccw;
   assign sens_trip  = s.cfg[fault_mgr_pkg::CFG_SENS_TRIP];
   assign model_trip = s.cfg[fault_mgr_pkg::CFG_MODEL_TRIP];
   assign ack        = trip_reset | s.cfg[fault_mgr_pkg::CFG_AUTORESET];
   assign c          = s.sync2;

   // Next-state logic
   always_comb
   begin
      next_s       = s;
      next_s.sync1 = cond_in;
      next_s.sync2 = s.sync1;
      next_s.cool  = cool_time;
      // Trip latches
      next_s.lat.mains = hold_latch(s.lat.mains, c.no_mains & motor_on,
                                    c.no_mains, trip_reset);    // [RULE6]
      next_s.lat.sens_sup = hold_latch(s.lat.sens_sup, c.sens_sup_ovl,
                                       c.sens_sup_ovl, trip_reset); // [RULE7]
      next_s.lat.t_ovl = hold_latch(s.lat.t_ovl, sens_trip & c.temp_ovl,
                                    c.temp_ovl, ack);           // [RULE9]
      next_s.lat.t_short = hold_latch(s.lat.t_short,
                                      sens_trip & c.temp_short,
                                      c.temp_short, ack);       // [RULE11]
      next_s.lat.t_break = hold_latch(s.lat.t_break,
                                      sens_trip & c.temp_break,
                                      c.temp_break, ack);       // [RULE12]
      next_s.lat.model = hold_latch(s.lat.model, model_trip & c.model_ovl,
                                    c.model_ovl | c.cooling, ack); // [RULE13]
      next_s.lat.selftest = s.lat.selftest | c.selftest_fail;   // [RULE14]
      next_s.lat.element  = s.lat.element | c.element_defect;   // [RULE15]
      next_s.lat.image = hold_latch(s.lat.image, c.image_err,
                                    c.image_err, ~motor_on);    // [RULE17]
      // Trip from latches or self-clearing undervoltage
      trip = c.elec_uv | c.sw_uv | s.lat.mains | s.lat.sens_sup
           | s.lat.t_ovl | s.lat.t_short | s.lat.t_break | s.lat.model
           | s.lat.selftest | s.lat.element | s.lat.image;      // [RULE16]
      // Signalling bits
      next_s.sig.gen_fault      = trip;
      next_s.sig.gen_warn       = (~sens_trip & (c.temp_ovl | c.temp_short
                                  | c.temp_break))
                                | (~model_trip & c.model_ovl); // [RULE8]
      next_s.sig.bus_fault      = ~bus_ok;                      // [RULE1]
      next_s.sig.master_stop    = bus_ok & ~master_run;         // [RULE2]
      next_s.sig.elec_low       = c.elec_uv;                    // [RULE3]
      next_s.sig.no_sw_supply   = c.sw_uv;                      // [RULE4]
      next_s.sig.no_mains       = c.no_mains | s.lat.mains;     // [RULE5]
      next_s.sig.sens_sup_ovl   = s.lat.sens_sup;
      next_s.sig.temp_ovl       = c.temp_ovl | s.lat.t_ovl;
      next_s.sig.temp_short     = c.temp_short | s.lat.t_short; // [RULE10]
      next_s.sig.temp_break     = c.temp_break | s.lat.t_break;
      next_s.sig.model_ovl      = c.model_ovl | s.lat.model;
      next_s.sig.ovl_trip       = s.lat.t_ovl | s.lat.t_short
                                | s.lat.t_break | s.lat.model;
      next_s.sig.cooling_active = s.lat.model & c.cooling;      // [RULE13]
      next_s.sig.selftest       = s.lat.selftest;
      next_s.sig.element_defect = s.lat.element;
      next_s.sig.image_err      = s.lat.image;
      // Lamps
      next_s.lmp.group_fault_lamp = trip ? fault_mgr_pkg::LAMP_RED
                                         : fault_mgr_pkg::LAMP_OFF;
      next_s.lmp.bus_fault_lamp = bus_ok ? fault_mgr_pkg::LAMP_OFF
                                         : fault_mgr_pkg::LAMP_RED;
      next_s.lmp.state_lamp = s.lat.element ? fault_mgr_pkg::LAMP_RED
                                            : fault_mgr_pkg::LAMP_OFF;
      if (s.lat.selftest | s.lat.element)
         next_s.lmp.device_lamp = fault_mgr_pkg::LAMP_RED;      // [RULE15]
      else if (trip)
         next_s.lmp.device_lamp = fault_mgr_pkg::LAMP_YELLOW;
      else if (next_s.sig.gen_warn)
         next_s.lmp.device_lamp = fault_mgr_pkg::LAMP_FLASH;
      else
         next_s.lmp.device_lamp = fault_mgr_pkg::LAMP_OFF;
      // Motor outputs
      if (trip)
      begin
         next_s.mcw  = 1'b0;                                    // [RULE18]
         next_s.mccw = 1'b0;
      end
      else if (~bus_ok | ~master_run)
      begin
         if (!s.cfg[fault_mgr_pkg::CFG_HOLD])
         begin
            next_s.mcw  = s.cfg[fault_mgr_pkg::CFG_SUB_CW];     // [RULE1]
            next_s.mccw = s.cfg[fault_mgr_pkg::CFG_SUB_CCW];    // [RULE2]
         end
      end
      else
      begin
         next_s.mcw  = cmd_cw;
         next_s.mccw = cmd_ccw;
      end
      // Interrupt events on rising signalling bits
      ev[fault_mgr_pkg::IRQ_FAULT] = next_s.sig.gen_fault & ~s.sig.gen_fault;
      ev[fault_mgr_pkg::IRQ_WARN]  = next_s.sig.gen_warn & ~s.sig.gen_warn;
      ev[fault_mgr_pkg::IRQ_BUS]   = next_s.sig.bus_fault & ~s.sig.bus_fault;
      ev[fault_mgr_pkg::IRQ_STOP]  = next_s.sig.master_stop
                                   & ~s.sig.master_stop;
      next_s.istat = s.istat | ev;
      // Register writes; event set wins over write-one clear
      if (wr)
      begin
         case (addr)
            fault_mgr_pkg::REG_CFG:
               next_s.cfg = wdata[fault_mgr_pkg::CFG_W-1:0];
            fault_mgr_pkg::REG_IRQ_STAT:
               next_s.istat = (s.istat & ~wdata[fault_mgr_pkg::IRQ_W-1:0])
                            | ev;
            fault_mgr_pkg::REG_IRQ_MASK:
               next_s.imask = wdata[fault_mgr_pkg::IRQ_W-1:0];
            default: ;
         endcase
      end
      // Read data valid in the cycle after the strobe only
      next_s.rdat = rd ? read_mux(addr, s) : 32'h0;
   end

   // State register
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s       <= '0;
         s.cfg   <= fault_mgr_pkg::CFG_RESET;
         s.istat <= fault_mgr_pkg::IRQ_RESET;
         s.imask <= fault_mgr_pkg::IRQ_RESET;
      end
      else
         s <= next_s;
   end

   // Outputs
   assign rdata     = s.rdat;
   assign motor_cw  = s.mcw;
   assign motor_ccw = s.mccw;
   assign signals   = s.sig;
   assign lamps     = s.lmp;
   assign irq       = |(s.istat & s.imask);

   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   // Bus, supply and latch behaviour
   AST_BUS_LOSS: assert property ( // [RULE1]
      !bus_ok |=> signals.bus_fault
                  && lamps.bus_fault_lamp == fault_mgr_pkg::LAMP_RED)
      else $error("bus loss not signalled");
   AST_MASTER_STOP: assert property ( // [RULE2]
      bus_ok && !master_run |=> signals.master_stop
                  && lamps.bus_fault_lamp == fault_mgr_pkg::LAMP_OFF)
      else $error("master stop not signalled");
   AST_ELEC_UV: assert property ( // [RULE3]
      c.elec_uv |=> signals.elec_low && signals.gen_fault
                  && lamps.group_fault_lamp == fault_mgr_pkg::LAMP_RED)
      else $error("electronics undervoltage not tripped");
   AST_MAINS_IDLE: assert property ( // [RULE5]
      c.no_mains && !motor_on && !s.lat.mains
      |=> signals.no_mains && !s.lat.mains)
      else $error("no mains with motor off latched a trip");
   AST_MAINS_HOLD: assert property ( // [RULE6]
      s.lat.mains && !trip_reset |=> s.lat.mains [*1] ##0 signals.gen_fault)
      else $error("mains trip cleared without trip reset");
   AST_SENS_SUP: assert property ( // [RULE7]
      s.lat.sens_sup && !trip_reset |=> s.lat.sens_sup)
      else $error("sensor supply trip cleared without reset");
   AST_SENS_WARN: assert property ( // [RULE8]
      !sens_trip && c.temp_ovl |=> signals.gen_warn && signals.temp_ovl
                  && lamps.device_lamp != fault_mgr_pkg::LAMP_OFF)
      else $error("sensor overload warning missing");
   AST_STILL_HOT: assert property ( // [RULE9]
      s.lat.t_ovl && c.temp_ovl |=> s.lat.t_ovl)
      else $error("reset accepted while motor hot");
   AST_COOLING: assert property ( // [RULE13]
      s.lat.model && c.cooling |=> s.lat.model && signals.cooling_active)
      else $error("model trip cleared during cooling");
   AST_POWER_ONLY: assert property ( // [RULE14]
      s.lat.selftest |=> s.lat.selftest
                  && lamps.device_lamp == fault_mgr_pkg::LAMP_RED)
      else $error("self-test fault cleared without power cycle");
   AST_MOTOR_OFF: assert property ( // [RULE18]
      signals.gen_fault |-> !motor_cw && !motor_ccw)
      else $error("motor energised during trip");

   // Supply, mains, sensor supply and self-test trips
   AST_SW_UV: assert property ( // [RULE4]
      c.sw_uv |=> signals.no_sw_supply && signals.gen_fault
                  && lamps.group_fault_lamp == fault_mgr_pkg::LAMP_RED)
      else $error("switching supply undervoltage not tripped");
   AST_MAINS_TRIP: assert property ( // [RULE6]
      c.no_mains && motor_on |=> s.lat.mains && signals.no_mains)
      else $error("no mains with motor on did not trip");
   AST_SENS_SUP_SET: assert property ( // [RULE7]
      c.sens_sup_ovl |=> s.lat.sens_sup)
      else $error("sensor supply overload not latched");
   AST_UV_LAMP: assert property ( // [RULE3]
      c.elec_uv && !s.lat.selftest && !s.lat.element
      |=> lamps.device_lamp == fault_mgr_pkg::LAMP_YELLOW)
      else $error("undervoltage device lamp not yellow");
   AST_SELFTEST_SET: assert property ( // [RULE14]
      c.selftest_fail |=> s.lat.selftest)
      else $error("self-test failure not latched");

   // Temperature sensor and motor model
   AST_SHORT_WARN: assert property ( // [RULE10]
      !sens_trip && c.temp_short |=> signals.gen_warn && signals.temp_short)
      else $error("sensor short warning missing");
   AST_SHORT_HOLD: assert property ( // [RULE11]
      s.lat.t_short && c.temp_short |=> s.lat.t_short && signals.ovl_trip)
      else $error("reset accepted before short removed");
   AST_BREAK_WARN: assert property ( // [RULE12]
      !sens_trip && c.temp_break |=> signals.gen_warn && signals.temp_break)
      else $error("sensor wire break warning missing");
   AST_BREAK_TRIP: assert property ( // [RULE12]
      sens_trip && c.temp_break |=> s.lat.t_break && signals.temp_break)
      else $error("sensor wire break trip not latched");
   AST_MODEL_SET: assert property ( // [RULE13]
      model_trip && c.model_ovl |=> s.lat.model && signals.model_ovl)
      else $error("model overload trip not latched");

   // Power-cycle faults, automatic clear and image error
   AST_ELEMENT: assert property ( // [RULE15]
      s.lat.element |=> s.lat.element
                  && lamps.state_lamp == fault_mgr_pkg::LAMP_RED
                  && lamps.device_lamp == fault_mgr_pkg::LAMP_RED)
      else $error("element defect cleared or lamps not red");
   AST_AUTO_CLEAR: assert property ( // [RULE16]
      !c.elec_uv && !c.sw_uv && s.lat == '0
      |=> !signals.gen_fault
          && lamps.group_fault_lamp == fault_mgr_pkg::LAMP_OFF)
      else $error("trip indicated without a cause");
   AST_IMAGE_ACK: assert property ( // [RULE17]
      s.lat.image && !motor_on && !c.image_err |=> !s.lat.image)
      else $error("image error not acknowledged by off command");
   AST_IMAGE_HOLD: assert property ( // [RULE17]
      s.lat.image && motor_on |=> s.lat.image)
      else $error("image error cleared while command active");
   AST_TRIP_OFF: assert property ( // [RULE18]
      trip |=> !motor_cw && !motor_ccw)
      else $error("motor command followed during trip");

   // Main scenarios reached
   COV_MAINS_TRIP: cover property (s.lat.mains ##1 !s.lat.mains);
   COV_SENS_TRIP: cover property (s.lat.t_ovl ##1 !s.lat.t_ovl);
   COV_IMAGE_ACK: cover property (s.lat.image ##1 !s.lat.image);
   COV_IRQ: cover property ($rose(irq));
   COV_MODEL_COOL: cover property (signals.cooling_active ##[1:20]
                                   !s.lat.model);
endmodule

/* File: core/fault_mgr_pkg.sv */
// Constants and carrier types of the motor starter fault manager.
// Assumes a single system clock; no timing constants are needed.
package fault_mgr_pkg;
   // Register byte offsets
   localparam logic [7:0] REG_CFG      = 8'h00;
   localparam logic [7:0] REG_SIGNAL   = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
   localparam logic [7:0] REG_COOL     = 8'h10;
   // Configuration fields
   localparam int CFG_W          = 6;
   localparam int CFG_HOLD       = 0;
   localparam int CFG_SENS_TRIP  = 1;
   localparam int CFG_MODEL_TRIP = 2;
   localparam int CFG_AUTORESET  = 3;
   localparam int CFG_SUB_CW     = 4;
   localparam int CFG_SUB_CCW    = 5;
   localparam logic [CFG_W-1:0] CFG_RESET = 6'h00;
   // Interrupt status and mask fields
   localparam int IRQ_W     = 4;
   localparam int IRQ_FAULT = 0;
   localparam int IRQ_WARN  = 1;
   localparam int IRQ_BUS   = 2;
   localparam int IRQ_STOP  = 3;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

   typedef enum logic [1:0] {
      LAMP_OFF,
      LAMP_RED,
      LAMP_YELLOW,
      LAMP_FLASH
   } lamp_t;

   // Detector levels from the power and sensor front end
   typedef struct packed {
      logic elec_uv;
      logic sw_uv;
      logic no_mains;
      logic sens_sup_ovl;
      logic temp_ovl;
      logic temp_short;
      logic temp_break;
      logic model_ovl;
      logic cooling;
      logic selftest_fail;
      logic element_defect;
      logic image_err;
   } cond_t;

   // Signalling bits, bit 0 is image_err
   typedef struct packed {
      logic gen_fault;
      logic gen_warn;
      logic bus_fault;
      logic master_stop;
      logic elec_low;
      logic no_sw_supply;
      logic no_mains;
      logic sens_sup_ovl;
      logic temp_ovl;
      logic temp_short;
      logic temp_break;
      logic model_ovl;
      logic ovl_trip;
      logic cooling_active;
      logic selftest;
      logic element_defect;
      logic image_err;
   } sig_t;

   typedef struct packed {
      lamp_t group_fault_lamp;
      lamp_t bus_fault_lamp;
      lamp_t state_lamp;
      lamp_t device_lamp;
   } lamps_t;

   // Latched trip causes
   typedef struct packed {
      logic mains;
      logic sens_sup;
      logic t_ovl;
      logic t_short;
      logic t_break;
      logic model;
      logic selftest;
      logic element;
      logic image;
   } latch_t;
endpackage

/* File: verification/bus_master_model.sv */
// Behavioural field bus master driving the fault manager's master side.
// Assumes the bench sets wanted levels; outputs follow one edge later.
`timescale 1ns/1ps
module bus_master_model (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset_n,
   // Wanted levels: bus, run, cw, ccw, trip reset
   input  wire logic [4:0] want,
   // Master outputs
   output      logic       bus_ok,
   output      logic       master_run,
   output      logic       cmd_cw,
   output      logic       cmd_ccw,
   output      logic       trip_reset
);
   // Register wanted levels; dropping both commands acks image errors
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         {bus_ok, master_run, cmd_cw, cmd_ccw, trip_reset} <= 5'h00;
      end
      else
      begin
         {bus_ok, master_run, cmd_cw, cmd_ccw, trip_reset}
            <= want;
      end
   end
endmodule

/* File: verification/tb_top.sv */
// Self-checking bench of the fault manager.
// Assumes the master model and the fault manager share clk_sys.
`timescale 1ns/1ps
module tb_top;
   localparam fault_mgr_pkg::lamp_t OFF = fault_mgr_pkg::LAMP_OFF;
   localparam fault_mgr_pkg::lamp_t RED = fault_mgr_pkg::LAMP_RED;
   localparam fault_mgr_pkg::lamp_t YEL = fault_mgr_pkg::LAMP_YELLOW;
   localparam fault_mgr_pkg::lamp_t FLS = fault_mgr_pkg::LAMP_FLASH;
   logic                   clk_sys, reset_n, wr, rd, irq;
   logic [7:0]             addr;
   logic [31:0]            wdata, rdata, v;
   logic                   bus_ok, master_run, cmd_cw, cmd_ccw, trip_reset;
   logic                   motor_cw, motor_ccw;
   logic [4:0]             want;
   logic [15:0]            cool_time;
   fault_mgr_pkg::cond_t   cnd;
   fault_mgr_pkg::sig_t    signals;
   fault_mgr_pkg::lamps_t  lamps;
   int                     bad_count, n_checks, i;
   bus_master_model u_mst (.clk_sys(clk_sys), .reset_n(reset_n),
      .want(want), .bus_ok(bus_ok), .master_run(master_run),
      .cmd_cw(cmd_cw), .cmd_ccw(cmd_ccw), .trip_reset(trip_reset));
   fault_manager u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .bus_ok(bus_ok),
      .master_run(master_run), .cmd_cw(cmd_cw), .cmd_ccw(cmd_ccw),
      .trip_reset(trip_reset), .cool_time(cool_time), .cond_in(cnd),
      .motor_cw(motor_cw), .motor_ccw(motor_ccw), .signals(signals),
      .lamps(lamps), .irq(irq));
   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic lck(input logic [1:0] g, input logic [1:0] d);
      chk(lamps.group_fault_lamp, g);
      chk(lamps.device_lamp, d);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // Register port cycles
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a);
      @(posedge clk_sys);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask
   // Master levels, detector levels, trip reset pulse
   task automatic mset(input logic [4:0] w);
      @(posedge clk_sys);
      want <= w;
      tick(3);
   endtask
   task automatic cset(input logic [11:0] c);
      @(posedge clk_sys);
      cnd <= c;
      tick(6);
   endtask
   task automatic trst(input logic [4:0] w);
      mset(w | 5'h01);
      mset(w);
   endtask
   task automatic wait_gf(input logic e);
      int k;
      for (k = 0; k < 20 && signals.gen_fault !== e; k++) tick(1);
      if (signals.gen_fault !== e)
      begin
         bad_count++;
         tally_and_finish();
      end
   endtask
   task automatic pcycle();
      @(posedge clk_sys);
      reset_n <= 1'b0;
      tick(2);
      @(posedge clk_sys);
      reset_n <= 1'b1;
      tick(3);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Clock
   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // Main sequence
   initial
   begin
      {reset_n, wr, rd, addr, wdata, cnd} = '0;
      want = 5'h18;
      cool_time = 16'h1234;
      bad_count = 0;
      n_checks = 0;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      tick(3);
      // Registers: reset values, read-only, unmapped
      rreg(fault_mgr_pkg::REG_CFG);
      chk(v, 32'h0);
      rreg(fault_mgr_pkg::REG_IRQ_MASK);
      chk(v, 32'h0);
      wreg(fault_mgr_pkg::REG_CFG, 32'h3f);
      rreg(fault_mgr_pkg::REG_CFG);
      chk(v, 32'h3f);
      wreg(fault_mgr_pkg::REG_SIGNAL, 32'hffff);
      rreg(fault_mgr_pkg::REG_SIGNAL);
      chk(v, 32'h0);
      rreg(8'h20);
      chk(v, 32'h0);
      rreg(fault_mgr_pkg::REG_COOL);
      chk(v, 32'h1234);
      // Bus loss with substitute cw, interrupt raise, mask, clear
      wreg(fault_mgr_pkg::REG_CFG, 32'h10);
      wreg(fault_mgr_pkg::REG_IRQ_STAT, 32'hf);
      wreg(fault_mgr_pkg::REG_IRQ_MASK, 32'h4);
      mset(5'h08);
      chk(signals.bus_fault, 1);
      chk(lamps.bus_fault_lamp, RED);
      chk({motor_cw, motor_ccw}, 2'b10);
      chk(irq, 1);
      rreg(fault_mgr_pkg::REG_IRQ_STAT);
      chk(v, 32'h4);
      mset(5'h18);
      chk({signals.bus_fault, lamps.bus_fault_lamp, motor_cw}, 0);
      wreg(fault_mgr_pkg::REG_IRQ_STAT, 32'h4);
      tick(1);
      chk(irq, 0);
      // Master stop with held output
      wreg(fault_mgr_pkg::REG_CFG, 32'h1);
      mset(5'h1c);
      mset(5'h10);
      chk({signals.master_stop, signals.bus_fault}, 2'b10);
      chk({lamps.bus_fault_lamp, motor_cw}, 3'b001);
      mset(5'h18);
      chk({signals.master_stop, motor_cw}, 0);
      wreg(fault_mgr_pkg::REG_CFG, 32'h0);
      // Supply undervoltage, self-acknowledged
      mset(5'h1c);
      for (i = 0; i < 2; i++)
      begin
         cset(i ? 12'h400 : 12'h800);
         wait_gf(1);
         chk({signals.elec_low, signals.no_sw_supply},
             2 - i);
         lck(RED, YEL);
         chk(motor_cw, 0);
         cset(12'h0);
         wait_gf(0);
         chk(motor_cw, 1);
      end
      // Missing mains, motor off then on
      mset(5'h18);
      cset(12'h200);
      chk({signals.no_mains, signals.gen_fault}, 2'b10);
      lck(OFF, OFF);
      cset(12'h0);
      chk(signals.no_mains, 0);
      mset(5'h1c);
      cset(12'h200);
      wait_gf(1);
      lck(RED, YEL);
      cset(12'h0);
      chk({signals.gen_fault, motor_cw}, 2'b10);
      trst(5'h1c);
      wait_gf(0);
      chk(motor_cw, 1);
      mset(5'h18);
      // Sensor supply overload ignores autoreset
      wreg(fault_mgr_pkg::REG_CFG, 32'h08);
      cset(12'h100);
      wait_gf(1);
      chk(signals.sens_sup_ovl, 1);
      cset(12'h0);
      chk(signals.gen_fault, 1);
      trst(5'h18);
      wait_gf(0);
      // Temperature sensor faults, warning then trip mode
      for (i = 0; i < 3; i++)
      begin
         wreg(fault_mgr_pkg::REG_CFG, 32'h0);
         cset(12'h080 >> i);
         chk({signals.gen_warn, signals.gen_fault},
             2'b10);
         chk({signals.temp_ovl, signals.temp_short, signals.temp_break},
             3'b100 >> i);
         lck(OFF, FLS);
         cset(12'h0);
         chk(signals.gen_warn, 0);
         wreg(fault_mgr_pkg::REG_CFG, 32'h2);
         cset(12'h080 >> i);
         wait_gf(1);
         chk(signals.ovl_trip, 1);
         lck(RED, YEL);
         trst(5'h18);
         chk(signals.gen_fault, 1);
         cset(12'h0);
         trst(5'h18);
         wait_gf(0);
      end
      // Motor model overload in warning mode clears itself
      cset(12'h010);
      chk({signals.gen_warn, signals.gen_fault}, 2'b10);
      lck(OFF, FLS);
      cset(12'h0);
      chk(signals.gen_warn, 0);
      // Motor model trip, autoreset only after cooling
      wreg(fault_mgr_pkg::REG_CFG, 32'h0c);
      cset(12'h018);
      wait_gf(1);
      chk({signals.model_ovl, signals.ovl_trip, signals.cooling_active},
          3'b111);
      cset(12'h008);
      chk({signals.gen_fault, signals.cooling_active}, 2'b11);
      cset(12'h0);
      wait_gf(0);
      wreg(fault_mgr_pkg::REG_CFG, 32'h0);
      // Self-test and element defect, cleared by power cycle
      for (i = 0; i < 2; i++)
      begin
         cset(i ? 12'h002 : 12'h004);
         wait_gf(1);
         chk({signals.selftest, signals.element_defect},
             2 - i);
         lck(RED, RED);
         chk(lamps.state_lamp, i ? RED : OFF);
         cset(12'h0);
         trst(5'h18);
         chk(signals.gen_fault, 1);
         pcycle();
         chk(signals.gen_fault, 0);
      end
      // Process image error, acked by withdrawing commands
      mset(5'h1c);
      cset(12'h001);
      wait_gf(1);
      chk({signals.image_err, motor_cw}, 2'b10);
      lck(RED, YEL);
      cset(12'h0);
      chk(signals.gen_fault, 1);
      mset(5'h18);
      wait_gf(0);
      tally_and_finish();
   end
endmodule
